// ### rtl/bsso_pkg.sv
// Purpose: Shared constants and carriers for the buck start-up, shutdown and overcurrent sequencer.
// Assumes: 250 MHz core clock; switching period set in core clocks by the frequency port.
// Notes: Millisecond times are derived from the clock rate.
package bsso_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int MS_NS = 1000000;
    localparam int CLK_NS = 4;
    localparam int MS_CYCLES = MS_NS / CLK_NS;
    localparam int OCP_SAMPLE_NS = 75;
    localparam int OCP_SAMPLE_CYC = (OCP_SAMPLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HICCUP_MS = 20;
    localparam logic [6:0] DELAY_MAX_MS = 7'h7f;
    // Fixed-slope ramp: 0.625 mV/us is one 0.625 mV code per us.
    localparam int SLOPE_STEP_NS = 1000;
    localparam int SLOPE_STEP_CYC = SLOPE_STEP_NS / CLK_NS;

    // ----------------------------------------
    // Switching period limits, 150 kHz to 1.5 MHz
    // ----------------------------------------
    localparam int FSW_MIN_KHZ = 150;
    localparam int FSW_MAX_KHZ = 1500;
    localparam logic [10:0] PERIOD_MAX = 11'(CLK_MHZ * 1000 / FSW_MIN_KHZ);
    localparam logic [10:0] PERIOD_MIN = 11'(CLK_MHZ * 1000 / FSW_MAX_KHZ);

    // ----------------------------------------
    // Prebias and overcurrent counts
    // ----------------------------------------
    localparam logic [4:0] PREBIAS_HOLD = 5'h10;
    localparam logic [3:0] OCP_TOTAL = 4'h8;
    localparam logic [2:0] OCP_RUN_DOWN = 3'h3;
    localparam logic [2:0] OCP_RUN_UP = 3'h4;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic parallel_code_mode;
        logic sw_enable_used;
        logic pin_enable_used;
        logic operation_off_allowed;
        logic soft_off;
        logic ocp_latch;
        logic cc_limit;
    } bsso_cfg_t;

    typedef struct packed {
        logic [6:0] ton_delay_ms;
        logic [6:0] ton_rise_ms;
        logic [6:0] toff_delay_ms;
        logic [6:0] toff_fall_ms;
    } bsso_times_t;

    // Duty cap: 0 = nominal, 1 = 1/2, 2 = 1/4, 3 = 1/8.
    typedef logic [1:0] bsso_cap_t;

endpackage

// ### rtl/bsso_pwm.sv
// Purpose: Switching-cycle timing: set pulse, valley sample window, high-side and low-side gates.
// Assumes: period in core clocks; duty in eighths of the period.
// Notes: Gates are registered; both drop in the cycle enable falls.
`timescale 1ns/1ps
module bsso_pwm
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic [10:0] period,
    input wire logic [3:0] hs_eighths,
    input wire logic prebias,
    input wire logic [3:0] ls_eighths,
    // Cycle events and gates
    output logic cycle_start,
    output logic sample_en,
    output logic hs_gate,
    output logic ls_gate,
    output logic first_hs
);
    logic [10:0] cnt_q;
    logic [13:0] pos8;
    logic [14:0] hs_end;
    logic [14:0] ls_end;
    logic hs_seen_q;

    assign pos8 = {cnt_q, 3'b000};
    assign hs_end = 15'(period) * 15'(hs_eighths + 4'h1);
    assign ls_end = 15'(period) * 15'(ls_eighths);

    always_ff @(posedge clk)
    begin
        if (rst || !run || cnt_q >= period - 11'h001)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 11'h001;
    end

    always_ff @(posedge clk)
    begin
        cycle_start <= run && cnt_q == '0;
        sample_en <= run && cnt_q < 11'(bsso_pkg::OCP_SAMPLE_CYC);
    end

    always_ff @(posedge clk)
    begin
        if (rst || !run)
        begin
            hs_gate <= 1'b0;
            ls_gate <= 1'b0;
        end
        else
        begin
            hs_gate <= hs_eighths != '0 && {1'b0, pos8} >= 15'(period) && {1'b0, pos8} < hs_end;
            // low side blocked until first pulse
            // The low side also waits for the high-side window to close, so the gates never overlap.
            ls_gate <= (!prebias || hs_seen_q) && {1'b0, pos8} >= hs_end
                       && {1'b0, pos8} >= 15'(period) * 15'(8) - ls_end;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || !run)
            hs_seen_q <= 1'b0;
        else if (hs_gate)
            hs_seen_q <= 1'b1;
    end

    assign first_hs = hs_seen_q;
endmodule

// ### rtl/bsso_ramp.sv
// Purpose: Reference ramp with programmable millisecond time or fixed slope.
// Assumes: Reference target and level in 0.625 mV codes.
// Notes: Programmed-time ramp steps once per ms by a fraction of the target.
`timescale 1ns/1ps
module bsso_ramp
#(
    parameter int MS_CYC = bsso_pkg::MS_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic go_up,
    input wire logic go_down,
    input wire logic fixed_slope,
    input wire logic [6:0] time_ms,
    input wire logic [11:0] target,
    // State
    output logic [11:0] level,
    output logic at_top,
    output logic at_zero
);
    logic [17:0] tick_q;
    logic [11:0] step;
    logic tick;

    assign tick = fixed_slope ? tick_q >= 18'(bsso_pkg::SLOPE_STEP_CYC - 1)
                              : tick_q >= 18'(MS_CYC - 1);
    assign step = fixed_slope ? 12'h001 : ((target / 12'(time_ms == '0 ? 7'h01 : time_ms)) | 12'h001);
    assign at_top = level >= target;
    assign at_zero = level == '0;

    always_ff @(posedge clk)
    begin
        if (rst || tick || !(go_up || go_down))
            tick_q <= '0;
        else
            tick_q <= tick_q + 18'h00001;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            level <= '0;
        else if (go_up && tick && !at_top)
            level <= (target - level < step) ? target : level + step;
        else if (go_down && tick && !at_zero)
            level <= (level < step) ? 12'h000 : level - step;
    end
endmodule

// ### rtl/bsso_top.sv
// Contract
// - Convert only with enable pin and bus voltage comparator at turn-on threshold.
// - Lockout and input faults use comparators only; ADC reading only reports.
// - Low side stays off until first high-side pulse at pre-biased start.
// - Low side starts one eighth period, steps one eighth every 16 cycles.
// - Ramp starts only after enable, bus voltage good and memory loaded.
// - Software enable usable instead of or together with the pin.
// - Bus mode: turn-on delay 0 to 127 ms in 1 ms steps.
// - Bus mode: rise time 1 to 127 ms, 1 ms resolution.
// - Parallel-code mode: no delay, fixed 0.625 mV/us slope.
// - Overcurrent and overvoltage protection active throughout start-up.
// - Switching frequency programmable from 150 kHz to 1.5 MHz.
// - Default: pin off drops both drivers at once.
// - Operation command may turn output off, optionally softly.
// - Bus mode soft-off: delay 0-127 ms then fall 1-127 ms.
// - Parallel-code soft-stop: 0.625 mV/us down, no delay.
// - Current reported at 1/16 A and in a byte at 1/4 A.
// - Warning from ADC average; fault from fast comparator.
// - Sample about 75 ns after set pulse; high side starts at its end. Code starts the high side one eighth period in.
// - Eight total trips: hiccup, drop enable 20 ms, restart.
// - Fault response selectable: latch off or hiccup, hiccup default.
// - Three consecutive trips halve the duty cap down to one eighth.
// - Four clean cycles double the cap back to nominal.
//
// Purpose: Sequencer top: enable, delays, ramps, shutdown, overcurrent handling.
// Assumes: Comparator inputs are asynchronous and pass three flip-flops, then a two-sample filter register.
// Notes: Time parameters can be shortened for simulation.
`timescale 1ns/1ps
module bsso_top
#(
    parameter int MS_CYC = bsso_pkg::MS_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Comparators, asynchronous
    input wire logic en_pin_cmp,
    input wire logic vin_on_cmp,
    input wire logic vin_ov_cmp,
    input wire logic vin_uv_warn_cmp,
    input wire logic ocp_cmp,
    input wire logic vout_ov_cmp,
    // Configuration
    input wire logic config_memory_loaded,
    input wire logic sw_enable,
    input wire logic operation_on,
    input wire bsso_pkg::bsso_cfg_t cfg,
    input wire bsso_pkg::bsso_times_t times,
    input wire logic [10:0] period_clk,
    input wire logic [11:0] vref_target,
    input wire logic [3:0] duty_eighths,
    input wire logic clear_faults,
    // Telemetry inputs
    input wire logic [11:0] iout_adc,
    input wire logic [11:0] iout_warn_limit,
    // Gates and reference
    output logic hs_drv_q,
    output logic ls_drv_q,
    output logic [11:0] reference_ramp_dac_q,
    // Status
    output logic conv_en_q,
    output logic vin_ov_fault_q,
    output logic vin_uv_warn_q,
    output logic vout_ov_fault_q,
    output logic oc_fault_q,
    output logic oc_warn_q,
    output logic latched_off_q,
    output logic [1:0] duty_cap_q,
    output logic [11:0] iout_sixteenth_q,
    output logic [7:0] iout_byte_q
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [5:0] s1_q, s2_q, s3_q, in_q;
    logic [5:0] async_in;
    logic en_pin, vin_ok, vin_ov, vin_uvw, oc_trip, vout_ov;

    assign async_in = {en_pin_cmp, vin_on_cmp, vin_ov_cmp, vin_uv_warn_cmp, ocp_cmp, vout_ov_cmp};
    always_ff @(posedge clk)
    begin
        s1_q <= async_in;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end
    genvar g;
    generate
        for (g = 0; g < 6; g++)
        begin : g_filt
            always_ff @(posedge clk)
            begin
                if (rst)
                    in_q[g] <= 1'b0;
                else if (s2_q[g] == s3_q[g])
                    in_q[g] <= s3_q[g];
            end
        end
    endgenerate
    assign {en_pin, vin_ok, vin_ov, vin_uvw, oc_trip, vout_ov} = in_q;

    // ----------------------------------------
    // Enable qualification
    // ----------------------------------------
    logic hw_ok, sw_ok, enable_req, hiccup_active, pin_drop;
    assign hw_ok = !cfg.pin_enable_used || en_pin;
    assign sw_ok = !cfg.sw_enable_used || sw_enable;
    assign enable_req = hw_ok && sw_ok && vin_ok && config_memory_loaded && !vin_ov
                        && !hiccup_active && !latched_off_q
                        && (!cfg.operation_off_allowed || operation_on);
    assign pin_drop = !(hw_ok && vin_ok && config_memory_loaded) || vin_ov;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    typedef enum logic [5:0] {
        ST_OFF = 6'b000001,
        ST_TON_DLY = 6'b000010,
        ST_RISE = 6'b000100,
        ST_ON = 6'b001000,
        ST_TOFF_DLY = 6'b010000,
        ST_FALL = 6'b100000
    } bsso_state_t;
    bsso_state_t st_q;
    logic [25:0] ms_cnt_q;
    logic [6:0] ms_q;
    logic ms_tick, ramp_top, ramp_zero, soft_ok;
    logic [11:0] ramp_level;

    assign ms_tick = ms_cnt_q >= 26'(MS_CYC - 1);
    // soft stop only when off came from the operation command or the software enable
    assign soft_ok = cfg.soft_off && cfg.operation_off_allowed && !pin_drop && !hiccup_active
                     && !latched_off_q;

    always_ff @(posedge clk)
    begin
        if (rst || ms_tick || !(st_q == ST_TON_DLY || st_q == ST_TOFF_DLY))
            ms_cnt_q <= '0;
        else
            ms_cnt_q <= ms_cnt_q + 26'h1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_q <= ST_OFF;
            ms_q <= '0;
        end
        else
        begin
            unique case (st_q)
                ST_OFF:
                    if (enable_req)
                    begin
                        ms_q <= '0;
                        st_q <= cfg.parallel_code_mode ? ST_RISE : ST_TON_DLY;
                    end
                ST_TON_DLY:
                    if (!enable_req)
                        st_q <= ST_OFF;
                    else if (ms_q >= times.ton_delay_ms)
                        st_q <= ST_RISE;
                    else if (ms_tick)
                        ms_q <= ms_q + 7'h01;
                ST_RISE, ST_ON:
                    if (!enable_req)
                    begin
                        ms_q <= '0;
                        st_q <= !soft_ok ? ST_OFF : cfg.parallel_code_mode ? ST_FALL : ST_TOFF_DLY;
                    end
                    else if (ramp_top)
                        st_q <= ST_ON;
                ST_TOFF_DLY:
                    if (!soft_ok)
                        st_q <= ST_OFF;
                    else if (ms_q >= times.toff_delay_ms)
                        st_q <= ST_FALL;
                    else if (ms_tick)
                        ms_q <= ms_q + 7'h01;
                ST_FALL:
                    if (!soft_ok || ramp_zero)
                        st_q <= ST_OFF;
            endcase
        end
    end

    bsso_ramp #(.MS_CYC(MS_CYC)) u_ramp
    (
        .clk(clk),
        .rst(rst || st_q == ST_OFF),
        .go_up(st_q == ST_RISE),
        .go_down(st_q == ST_FALL),
        .fixed_slope(cfg.parallel_code_mode),
        .time_ms(st_q == ST_FALL ? times.toff_fall_ms : times.ton_rise_ms),
        .target(vref_target),
        .level(ramp_level),
        .at_top(ramp_top),
        .at_zero(ramp_zero)
    );

    logic running;
    assign running = st_q == ST_RISE || st_q == ST_ON || st_q == ST_FALL;

    // ----------------------------------------
    // Switching and prebias stepping
    // ----------------------------------------
    logic [10:0] period;
    logic [3:0] ls_step_q, hs_duty;
    logic [4:0] hold_q;
    logic cyc, samp, hs_g, ls_g, first_hs;

    assign period = period_clk > bsso_pkg::PERIOD_MAX ? bsso_pkg::PERIOD_MAX :
                    period_clk < bsso_pkg::PERIOD_MIN ? bsso_pkg::PERIOD_MIN : period_clk;
    assign hs_duty = (duty_cap_q == 2'd0 || duty_eighths <= (4'h8 >> duty_cap_q)) ? duty_eighths
                                                                                  : (4'h8 >> duty_cap_q);

    bsso_pwm u_pwm
    (
        .clk(clk),
        .rst(rst),
        .run(running),
        .period(period),
        .hs_eighths(hs_duty),
        .prebias(1'b1),
        .ls_eighths(ls_step_q),
        .cycle_start(cyc),
        .sample_en(samp),
        .hs_gate(hs_g),
        .ls_gate(ls_g),
        .first_hs(first_hs)
    );

    always_ff @(posedge clk)
    begin
        if (rst || !running || !first_hs)
        begin
            ls_step_q <= 4'h1;
            hold_q <= '0;
        end
        else if (cyc && ls_step_q < 4'h8 - hs_duty)
        begin
            if (hold_q == bsso_pkg::PREBIAS_HOLD - 5'h01)
            begin
                hold_q <= '0;
                ls_step_q <= ls_step_q + 4'h1;
            end
            else
                hold_q <= hold_q + 5'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        hs_drv_q <= !rst && running && hs_g;
        ls_drv_q <= !rst && running && ls_g;
        reference_ramp_dac_q <= rst ? 12'h000 : ramp_level;
        conv_en_q <= !rst && running;
    end

    // ----------------------------------------
    // Overcurrent
    // ----------------------------------------
    logic samp_hit_q, samp_d1_q;
    logic [3:0] oc_total_q;
    logic [2:0] run_hi_q, run_lo_q;
    logic [25:0] hic_cnt_q;
    logic [4:0] hic_ms_q;
    logic cyc_oc;

    always_ff @(posedge clk)
    begin
        samp_d1_q <= !rst && samp;
        if (rst || cyc)
            samp_hit_q <= 1'b0;
        else if (samp && oc_trip)
            samp_hit_q <= 1'b1;
    end
    assign cyc_oc = samp_hit_q;

    // counting active in every running state
    always_ff @(posedge clk)
    begin
        if (rst || !running)
        begin
            oc_total_q <= '0;
            run_hi_q <= '0;
            run_lo_q <= '0;
            duty_cap_q <= '0;
        end
        else if (cyc)
        begin
            if (cyc_oc)
            begin
                oc_total_q <= oc_total_q + 4'h1;
                run_lo_q <= '0;
                if (cfg.cc_limit && run_hi_q == bsso_pkg::OCP_RUN_DOWN - 3'h1)
                begin
                    run_hi_q <= '0;
                    if (duty_cap_q != 2'd3 && duty_eighths > (4'h8 >> (duty_cap_q + 2'd1)))
                        duty_cap_q <= duty_cap_q + 2'd1;
                end
                else
                    run_hi_q <= run_hi_q + 3'h1;
            end
            else
            begin
                run_hi_q <= '0;
                if (run_lo_q == bsso_pkg::OCP_RUN_UP - 3'h1)
                begin
                    run_lo_q <= '0;
                    if (duty_cap_q != 2'd0)
                        duty_cap_q <= duty_cap_q - 2'd1;
                end
                else
                    run_lo_q <= run_lo_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hiccup_active <= 1'b0;
            latched_off_q <= 1'b0;
            hic_cnt_q <= '0;
            hic_ms_q <= '0;
        end
        else if (running && oc_total_q == bsso_pkg::OCP_TOTAL)
        begin
            hiccup_active <= !cfg.ocp_latch;
            latched_off_q <= cfg.ocp_latch;
            hic_cnt_q <= '0;
            hic_ms_q <= '0;
        end
        else if (hiccup_active)
        begin
            hic_cnt_q <= hic_cnt_q >= 26'(MS_CYC - 1) ? 26'h0 : hic_cnt_q + 26'h1;
            if (hic_cnt_q >= 26'(MS_CYC - 1))
            begin
                if (hic_ms_q == 5'(bsso_pkg::HICCUP_MS - 1))
                    hiccup_active <= 1'b0;
                hic_ms_q <= hic_ms_q + 5'h01;
            end
        end
        else if (!en_pin && cfg.pin_enable_used)
            latched_off_q <= 1'b0;
    end

    // ----------------------------------------
    // Fault flags and telemetry
    // ----------------------------------------
    // host clear; set wins over clear
    // fault from comparator, current warning from ADC
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            oc_fault_q <= 1'b0;
            vout_ov_fault_q <= 1'b0;
            vin_ov_fault_q <= 1'b0;
            vin_uv_warn_q <= 1'b0;
            oc_warn_q <= 1'b0;
        end
        else
        begin
            oc_fault_q <= (samp_d1_q && oc_trip) || (oc_fault_q && !clear_faults);
            vout_ov_fault_q <= vout_ov || (vout_ov_fault_q && !clear_faults);
            vin_ov_fault_q <= vin_ov || (vin_ov_fault_q && !clear_faults);
            vin_uv_warn_q <= vin_uvw || (vin_uv_warn_q && !clear_faults);
            oc_warn_q <= (iout_adc > iout_warn_limit) || (oc_warn_q && !clear_faults);
        end
    end

    // 1/16 A and 1/4 A readback
    always_ff @(posedge clk)
    begin
        iout_sixteenth_q <= rst ? 12'h000 : iout_adc;
        iout_byte_q <= rst ? 8'h00 : (iout_adc[11:10] != 2'b00 ? 8'hff : iout_adc[9:2]);
    end
endmodule

// ### tb/bsso_partner.sv
// Purpose: Far-side model: supply comparators and valley current comparator.
// Assumes: Bus level in millivolts; enable pin fed from a divider on the bus.
// Notes: Thresholds are plain defaults, not taken from any part.
`timescale 1ns/1ps
module bsso_partner
#(
    parameter int EN_MV = 9000,
    parameter int ON_MV = 8000,
    parameter int OFF_MV = 7000,
    parameter int OV_MV = 15000
)
(
    // Supply and load
    input wire logic [15:0] bus_mv,
    input wire logic overload,
    input wire logic hs_drv_q,
    // Comparators
    output logic en_pin_cmp,
    output logic vin_on_cmp,
    output logic vin_ov_cmp,
    output logic ocp_cmp
);
    assign en_pin_cmp = (bus_mv >= EN_MV);
    assign vin_ov_cmp = (bus_mv > OV_MV);
    // Valley sensed while high side off.
    assign ocp_cmp = overload && !hs_drv_q;

    // Turn-on hysteresis, evaluated from time zero.
    always_latch
    begin
        if (bus_mv >= ON_MV)
            vin_on_cmp <= 1'b1;
        else if (bus_mv < OFF_MV)
            vin_on_cmp <= 1'b0;
    end
endmodule

// ### tb/bsso_top_monitor.sv
// Purpose: Port checker for the buck sequencer top.
// Assumes: Comparator filter plus register take at most six clocks.
// Notes: Bound to every bsso_top instance.
`timescale 1ns/1ps
module bsso_top_monitor
#(
    parameter int MS_CYC = 50
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Inputs
    input wire logic en_pin_cmp,
    input wire logic vin_on_cmp,
    input wire logic vout_ov_cmp,
    input wire logic config_memory_loaded,
    input wire bsso_pkg::bsso_cfg_t cfg,
    input wire logic [11:0] iout_adc,
    input wire logic [11:0] iout_warn_limit,
    // Outputs
    input wire logic hs_drv_q,
    input wire logic ls_drv_q,
    input wire logic [11:0] reference_ramp_dac_q,
    input wire logic conv_en_q,
    input wire logic vout_ov_fault_q,
    input wire logic oc_warn_q,
    input wire logic [1:0] duty_cap_q,
    input wire logic [11:0] iout_sixteenth_q,
    input wire logic [7:0] iout_byte_q
);
    // Cleared only when fully idle, so a restart must again show a high-side pulse first.
    logic seen_hs_q;

    always_ff @(posedge clk)
    begin
        if (rst || (!conv_en_q && !ls_drv_q && reference_ramp_dac_q == 12'h000))
            seen_hs_q <= 1'b0;
        else if (hs_drv_q)
            seen_hs_q <= 1'b1;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    pin_off_gates_a: assert property ((cfg.pin_enable_used && !en_pin_cmp) [*7] |-> !hs_drv_q && !ls_drv_q)
        else $error("gate on with enable pin low");
    vin_low_off_a: assert property ((!vin_on_cmp) [*7] |-> !conv_en_q)
        else $error("enabled with bus voltage low");
    ls_after_hs_a: assert property (ls_drv_q |-> seen_hs_q)
        else $error("low side before first high side");
    enable_needs_load_a: assert property ($rose(conv_en_q) |-> $past(config_memory_loaded))
        else $error("enabled before memory loaded");
    cap_one_step_a: assert property ($changed(duty_cap_q) |-> duty_cap_q == 2'($past(duty_cap_q) + 2'h1)
        || duty_cap_q == 2'($past(duty_cap_q) - 2'h1) || duty_cap_q == 2'h0)
        else $error("duty cap jumped");
    byte_scale_a: assert property (iout_sixteenth_q == $past(iout_sixteenth_q) |->
        iout_byte_q == ((|iout_sixteenth_q[11:10]) ? 8'hff : iout_sixteenth_q[9:2]))
        else $error("current byte scale wrong");
    vout_ov_seen_a: assert property (vout_ov_cmp [*6] |-> vout_ov_fault_q)
        else $error("output overvoltage missed");
    oc_warn_seen_a: assert property ((iout_adc > iout_warn_limit) [*4] |-> oc_warn_q)
        else $error("current warning missed");

    cover property ($rose(conv_en_q));
    cover property (duty_cap_q == 2'h2);
    cover property ($fell(duty_cap_q == 2'h1) && duty_cap_q == 2'h0);
endmodule

bind bsso_top bsso_top_monitor #(.MS_CYC(MS_CYC)) mon (.clk(clk), .rst(rst), .en_pin_cmp(en_pin_cmp),
    .vin_on_cmp(vin_on_cmp), .vout_ov_cmp(vout_ov_cmp), .config_memory_loaded(config_memory_loaded),
    .cfg(cfg), .iout_adc(iout_adc), .iout_warn_limit(iout_warn_limit), .hs_drv_q(hs_drv_q),
    .ls_drv_q(ls_drv_q), .reference_ramp_dac_q(reference_ramp_dac_q), .conv_en_q(conv_en_q),
    .vout_ov_fault_q(vout_ov_fault_q), .oc_warn_q(oc_warn_q), .duty_cap_q(duty_cap_q),
    .iout_sixteenth_q(iout_sixteenth_q), .iout_byte_q(iout_byte_q));

// ### tb/test_bsso_top.sv
// Purpose: Self-checking bench for the buck sequencer.
// Assumes: One millisecond shortened to 50 clocks.
// Notes: Inputs change on the falling edge, except one bus drop made on a rising edge of the high-side gate.
`timescale 1ns/1ps
module test_bsso_top;
    localparam int MS = 50;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] bus_mv = 16'h2ee0;
    logic overload = 1'b0;
    logic vout_ov = 1'b0;
    logic loaded = 1'b0;
    logic sw_en = 1'b1;
    logic op_on = 1'b1;
    logic clr = 1'b0;
    logic [11:0] iout = 12'h0a0;
    bsso_pkg::bsso_cfg_t cfg = 7'h11;
    bsso_pkg::bsso_times_t times = '{7'h02, 7'h01, 7'h00, 7'h01};
    logic en_c, von_c, vov_c, ocp_c, hs, ls, conv_en, ovf, ocf, ocw, latched, vof;
    logic [11:0] ref_dac, i16;
    logic [1:0] cap;
    logic [7:0] ib;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int n;

    always #2 clk = ~clk;

    bsso_partner far (.bus_mv(bus_mv), .overload(overload), .hs_drv_q(hs), .en_pin_cmp(en_c),
        .vin_on_cmp(von_c), .vin_ov_cmp(vov_c), .ocp_cmp(ocp_c));

    bsso_top #(.MS_CYC(MS)) dut (.clk(clk), .rst(rst), .en_pin_cmp(en_c), .vin_on_cmp(von_c),
        .vin_ov_cmp(vov_c), .vin_uv_warn_cmp(1'b0), .ocp_cmp(ocp_c), .vout_ov_cmp(vout_ov),
        .config_memory_loaded(loaded), .sw_enable(sw_en), .operation_on(op_on), .cfg(cfg), .times(times),
        .period_clk(11'h0a6), .vref_target(12'h010), .duty_eighths(4'h5), .clear_faults(clr),
        .iout_adc(iout), .iout_warn_limit(12'h080), .hs_drv_q(hs), .ls_drv_q(ls),
        .reference_ramp_dac_q(ref_dac), .conv_en_q(conv_en), .vin_ov_fault_q(vof), .vin_uv_warn_q(),
        .vout_ov_fault_q(ovf), .oc_fault_q(ocf), .oc_warn_q(ocw), .latched_off_q(latched),
        .duty_cap_q(cap), .iout_sixteenth_q(i16), .iout_byte_q(ib));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
            err_count++;
        if (got !== exp)
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic ls_width(output int w);
        wait (ls === 1'b1);
        w = 0;
        while (ls === 1'b1)
        begin
            @(negedge clk);
            w++;
        end
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_count++;
            test_done();
        end
    end

    initial
    begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (40) @(negedge clk);
        chk(conv_en, 1'b0);
        loaded = 1'b1;
        n = 0;
        while (conv_en !== 1'b1)
        begin
            @(negedge clk);
            n++;
        end
        chk(n >= 2 * MS && n <= 2 * MS + 8, 1'b1);
        chk(ref_dac, 12'h000);
        n = 0;
        while (ref_dac !== 12'h010)
        begin
            @(negedge clk);
            n++;
        end
        chk(n >= MS - 2 && n <= MS + 4, 1'b1);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        chk({ocw, ib}, 9'h128);
        chk(i16, 12'h0a0);
        $display("start-up test done");
        overload = 1'b1;
        wait (cap === 2'h2);
        chk(conv_en, 1'b1);
        wait (conv_en === 1'b0);
        @(negedge clk);
        overload = 1'b0;
        chk(ocf, 1'b1);
        n = 0;
        while (conv_en === 1'b0)
        begin
            @(negedge clk);
            n++;
        end
        chk(n >= 22 * MS && n <= 22 * MS + 8, 1'b1);
        ls_width(n);
        chk(n >= 19 && n <= 22, 1'b1);
        repeat (15) ls_width(n);
        ls_width(n);
        chk(n >= 40 && n <= 43, 1'b1);
        overload = 1'b1;
        repeat (3) @(posedge hs);
        @(negedge clk);
        overload = 1'b0;
        wait (cap === 2'h1);
        chk(conv_en, 1'b1);
        n = 0;
        while (cap !== 2'h0)
        begin
            @(posedge hs);
            n++;
        end
        chk(n >= 3 && n <= 5, 1'b1);
        $display("overcurrent test done");
        bus_mv = 16'h1f40;
        repeat (8) @(negedge clk);
        chk({conv_en, hs, ls}, 3'h0);
        cfg.ocp_latch = 1'b1;
        bus_mv = 16'h2ee0;
        wait (conv_en === 1'b1);
        @(negedge clk);
        overload = 1'b1;
        wait (latched === 1'b1);
        @(negedge clk);
        overload = 1'b0;
        repeat (30 * MS) @(negedge clk);
        chk(conv_en, 1'b0);
        bus_mv = 16'h1f40;
        cfg = 7'h5d;
        repeat (8) @(negedge clk);
        bus_mv = 16'h2ee0;
        wait (conv_en === 1'b1);
        n = 0;
        while (ref_dac !== 12'h010)
        begin
            @(negedge clk);
            n++;
        end
        chk(n >= 3990 && n <= 4010, 1'b1);
        op_on = 1'b0;
        n = 0;
        while (ref_dac !== 12'h000)
        begin
            @(negedge clk);
            n++;
        end
        chk(n >= 3990 && n <= 4010, 1'b1);
        $display("shutdown test done");
        vout_ov = 1'b1;
        bus_mv = 16'h3e80;
        repeat (8) @(negedge clk);
        chk(ovf, 1'b1);
        chk(vof, 1'b1);
        $display("protection test done");
        test_done();
    end
endmodule
